// *** logic/ccr_regs.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Watchdog period change restarts watchdog counter
// - Safety duration change restarts safety timer
// - Control one bit 7 enables termination
// - Kick bit restarts watchdog, self clears
// - Watchdog period: off, 40, 80, 160 s
// - Control one bit 3 enables safety timer
// - Safety duration 5, 8, 12, 20 hours
// - Slowdown halves timer rate during regulation
// - Expiry holds charger enable cleared until watchdog restart (kick or period change)
// - Thermal threshold field in bits 5-4
// - Control two bit 3 charger enable, resets 0
// - Low battery field survives watchdog expiry
// - Status bit 7 shows power good, bits 6..4 regulation conditions
// - Status bit 3 shows watchdog expired
// - Charge state 0 idle, 3 CC, 4 CV
// - Fault bits 7..4 held clear after expiry until kick or period change
// - Fault bits 7..4 show protection conditions
// - Weak adapter bit after seven failed detections
// - Fault bit 2 shows capacitor precharge failure
// - Reserved bits read zero
// - Control one at address 5, reset 9D
module ccr_regs #(
    parameter longint WD_BASE_CYCLES = ccr_pkg::WD_BASE_CYC,
    parameter longint HOUR_CYCLES = ccr_pkg::HOUR_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire ccr_pkg::ccr_req_s i_req,
    input wire ccr_pkg::ccr_cond_s i_cond,
    input wire logic i_weak_detect_done,
    input wire logic i_weak_detect_fail,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_term_enable,
    output logic o_charger_enable,
    output logic o_safety_timer_enable,
    output logic o_safety_expired,
    output logic o_host_timeout_expired,
    output logic [1:0] o_thermal_threshold_select,
    output logic [1:0] o_low_battery_threshold
);

    // Elaboration-time refusal of counts the timers cannot serve
    if (WD_BASE_CYCLES < 1 || HOUR_CYCLES < 1) begin : g_bad_cycles
        $error("ccr_regs: cycle counts must be positive");
    end

    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [63:0] wd_cnt;
        logic wd_expired;
        logic [63:0] tmr_cnt;
        logic tmr_half;
        logic tmr_expired;
        logic [2:0] weak_fails;
        logic [7:0] rdata;
        logic rvalid;
    } ccr_state_s;

    ccr_state_s st_q;
    ccr_state_s st_d;

    logic [63:0] wd_limit;
    logic [63:0] tmr_limit;
    logic [1:0] wd_per_new;
    logic [1:0] dur_new;
    logic kick;
    logic wd_restart;
    logic tmr_restart;
    logic in_reg;
    logic [7:0] cond_byte;
    logic [7:0] fault_byte;

    always_comb begin
        wd_limit = 64'h0;
        case (st_q.ctrl_one[ccr_pkg::CTRL_ONE_WD_LSB +: 2])
            2'h1: wd_limit = 64'(WD_BASE_CYCLES);
            2'h2: wd_limit = 64'(WD_BASE_CYCLES * 2);
            2'h3: wd_limit = 64'(WD_BASE_CYCLES * 4);
            default: wd_limit = 64'h0;
        endcase
        tmr_limit = 64'h0;
        case (st_q.ctrl_one[ccr_pkg::CTRL_ONE_DUR_LSB +: 2])
            2'h0: tmr_limit = 64'(HOUR_CYCLES * ccr_pkg::DUR0_H);
            2'h1: tmr_limit = 64'(HOUR_CYCLES * ccr_pkg::DUR1_H);
            2'h2: tmr_limit = 64'(HOUR_CYCLES * ccr_pkg::DUR2_H);
            default: tmr_limit = 64'(HOUR_CYCLES * ccr_pkg::DUR3_H);
        endcase
    end

    always_comb begin
        logic wr1;
        logic wr2;
        wr1 = i_req.wr && i_req.addr == ccr_pkg::ADDR_CTRL_ONE;
        wr2 = i_req.wr && i_req.addr == ccr_pkg::ADDR_CTRL_TWO;
        wd_per_new = i_req.wdata[ccr_pkg::CTRL_ONE_WD_LSB +: 2];
        dur_new = i_req.wdata[ccr_pkg::CTRL_ONE_DUR_LSB +: 2];
        kick = wr1 && i_req.wdata[ccr_pkg::CTRL_ONE_KICK_BIT];
        wd_restart = kick || (wr1 && wd_per_new !=
            st_q.ctrl_one[ccr_pkg::CTRL_ONE_WD_LSB +: 2]);
        tmr_restart = wr1 && dur_new !=
            st_q.ctrl_one[ccr_pkg::CTRL_ONE_DUR_LSB +: 2];
        in_reg = i_cond.input_current_reg || i_cond.input_voltage_reg ||
            i_cond.thermal_reg;

        cond_byte = {i_cond.power_good, i_cond.input_current_reg,
            i_cond.input_voltage_reg, i_cond.thermal_reg,
            st_q.wd_expired, i_cond.charge_state};
        fault_byte = {i_cond.input_overvoltage, i_cond.thermal_shutdown,
            i_cond.battery_overvoltage, i_cond.flying_cap_fault,
            1'b0, i_cond.cap_precharge_fail,
            st_q.weak_fails == 3'h7, 1'b0};
        if (st_q.wd_expired) begin
            fault_byte[7:4] = 4'h0;
        end

        st_d = st_q;
        st_d.rvalid = i_req.rd;
        st_d.rdata = 8'h00;
        if (i_req.rd) begin
            case (i_req.addr)
                ccr_pkg::ADDR_CTRL_ONE: st_d.rdata = st_q.ctrl_one;
                ccr_pkg::ADDR_CTRL_TWO: st_d.rdata = st_q.ctrl_two;
                ccr_pkg::ADDR_COND_STAT: st_d.rdata = cond_byte;
                ccr_pkg::ADDR_FAULT_STAT: st_d.rdata = fault_byte;
                default: st_d.rdata = 8'h00;
            endcase
        end

        if (wr1) begin
            st_d.ctrl_one = i_req.wdata & ccr_pkg::CTRL_ONE_MASK;
            st_d.ctrl_one[ccr_pkg::CTRL_ONE_KICK_BIT] = 1'b0;
        end
        if (wr2) begin
            st_d.ctrl_two = i_req.wdata & ccr_pkg::CTRL_TWO_MASK;
        end

        // Watchdog
        if (wd_restart) begin
            st_d.wd_cnt = 64'h0;
            st_d.wd_expired = 1'b0;
        end else if (wd_limit != 64'h0 && !st_q.wd_expired) begin
            if (st_q.wd_cnt + 64'h1 >= wd_limit) begin
                st_d.wd_expired = 1'b1;
                st_d.wd_cnt = 64'h0;
                // Expiry reload; low battery field is kept
                st_d.ctrl_one = ccr_pkg::CTRL_ONE_RST;
                st_d.ctrl_two = (ccr_pkg::CTRL_TWO_RST &
                    ~ccr_pkg::CTRL_TWO_LOWV_MASK) | (st_d.ctrl_two &
                    ccr_pkg::CTRL_TWO_LOWV_MASK);
            end else begin
                st_d.wd_cnt = st_q.wd_cnt + 64'h1;
            end
        end
        if (st_q.wd_expired && !wd_restart) begin
            st_d.ctrl_two[ccr_pkg::CTRL_TWO_CHG_EN_BIT] = 1'b0;
        end

        // Safety timer
        if (tmr_restart || st_d.wd_expired) begin
            st_d.tmr_cnt = 64'h0;
            st_d.tmr_half = 1'b0;
            st_d.tmr_expired = 1'b0;
        end else if (st_q.ctrl_one[ccr_pkg::CTRL_ONE_TMR_EN_BIT] &&
                st_q.ctrl_two[ccr_pkg::CTRL_TWO_CHG_EN_BIT] &&
                i_cond.charge_state != ccr_pkg::CHG_IDLE) begin
            st_d.tmr_half = ~st_q.tmr_half;
            if (!(st_q.ctrl_one[ccr_pkg::CTRL_ONE_SLOW_BIT] && in_reg &&
                    st_q.tmr_half)) begin
                if (st_q.tmr_cnt + 64'h1 >= tmr_limit) begin
                    st_d.tmr_expired = 1'b1;
                end else begin
                    st_d.tmr_cnt = st_q.tmr_cnt + 64'h1;
                end
            end
        end else if (!st_q.ctrl_one[ccr_pkg::CTRL_ONE_TMR_EN_BIT]) begin
            st_d.tmr_cnt = 64'h0;
            st_d.tmr_expired = 1'b0;
        end

        // Weak adapter consecutive failures
        if (i_weak_detect_done) begin
            if (!i_weak_detect_fail) begin
                st_d.weak_fails = 3'h0;
            end else if (st_q.weak_fails != 3'h7) begin
                st_d.weak_fails = st_q.weak_fails + 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0;
            st_q.ctrl_one <= ccr_pkg::CTRL_ONE_RST;
            st_q.ctrl_two <= ccr_pkg::CTRL_TWO_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata = st_q.rdata;
    assign o_rvalid = st_q.rvalid;
    assign o_term_enable = st_q.ctrl_one[ccr_pkg::CTRL_ONE_TERM_BIT];
    assign o_charger_enable =
        st_q.ctrl_two[ccr_pkg::CTRL_TWO_CHG_EN_BIT];
    assign o_safety_timer_enable =
        st_q.ctrl_one[ccr_pkg::CTRL_ONE_TMR_EN_BIT];
    assign o_safety_expired = st_q.tmr_expired;
    assign o_host_timeout_expired = st_q.wd_expired;
    assign o_thermal_threshold_select =
        st_q.ctrl_two[ccr_pkg::CTRL_TWO_TREG_LSB +: 2];
    assign o_low_battery_threshold =
        st_q.ctrl_two[ccr_pkg::CTRL_TWO_LOWV_LSB +: 2];

endmodule

// *** logic/ccr_pkg.sv ***
package ccr_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h05;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h06;
    localparam logic [7:0] ADDR_COND_STAT = 8'h07;
    localparam logic [7:0] ADDR_FAULT_STAT = 8'h08;

    // Reset values
    localparam logic [7:0] CTRL_ONE_RST = 8'h9D;
    localparam logic [7:0] CTRL_TWO_RST = 8'h33;

    // Field positions, control one
    localparam int CTRL_ONE_TERM_BIT = 7;
    localparam int CTRL_ONE_KICK_BIT = 6;
    localparam int CTRL_ONE_WD_LSB = 4;
    localparam int CTRL_ONE_TMR_EN_BIT = 3;
    localparam int CTRL_ONE_DUR_LSB = 1;
    localparam int CTRL_ONE_SLOW_BIT = 0;
    // Field positions, control two
    localparam int CTRL_TWO_TREG_LSB = 4;
    localparam int CTRL_TWO_CHG_EN_BIT = 3;
    localparam int CTRL_TWO_LOWV_LSB = 0;
    // Writable bit masks; reserved bits read zero
    localparam logic [7:0] CTRL_ONE_MASK = 8'hFF;
    localparam logic [7:0] CTRL_TWO_MASK = 8'h3B;
    localparam logic [7:0] CTRL_TWO_LOWV_MASK = 8'h03;

    // Timing
    localparam longint CLK_HZ = 50000000;
    localparam longint WD_BASE_S = 40;
    localparam longint WD_BASE_CYC = WD_BASE_S * CLK_HZ;
    localparam longint HOUR_S = 3600;
    localparam longint HOUR_CYC = HOUR_S * CLK_HZ;
    localparam longint DUR0_H = 5;
    localparam longint DUR1_H = 8;
    localparam longint DUR2_H = 12;
    localparam longint DUR3_H = 20;

    localparam logic [2:0] CHG_IDLE = 3'h0;
    localparam logic [2:0] CHG_CC = 3'h3;
    localparam logic [2:0] CHG_CV = 3'h4;

    typedef struct packed {
        logic power_good;
        logic input_current_reg;
        logic input_voltage_reg;
        logic thermal_reg;
        logic [2:0] charge_state;
        logic input_overvoltage;
        logic thermal_shutdown;
        logic battery_overvoltage;
        logic flying_cap_fault;
        logic cap_precharge_fail;
        logic weak_adapter_fail;
    } ccr_cond_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccr_req_s;

endpackage

// *** dv/ccr_regs_properties.sv ***
`timescale 1ns/1ps
module ccr_regs_properties (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire ccr_pkg::ccr_req_s i_req,
    input wire ccr_pkg::ccr_cond_s i_cond,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_term_enable,
    input wire logic o_charger_enable,
    input wire logic o_safety_timer_enable,
    input wire logic o_host_timeout_expired,
    input wire logic [1:0] o_thermal_threshold_select,
    input wire logic [1:0] o_low_battery_threshold
);
    ccr_pkg::ccr_cond_s c_q;
    ccr_pkg::ccr_req_s r_q;
    logic x_q;
    always_ff @(posedge i_clk_sys) begin
        c_q <= i_cond;
        r_q <= i_req;
        x_q <= o_host_timeout_expired;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    rvalid_timing_a: assert property (o_rvalid == $past(i_req.rd))
        else $error("rvalid timing");
    cond_read_a: assert property (r_q.rd && r_q.addr == 8'h07 |->
        o_rdata == {c_q[12:9], x_q, c_q.charge_state})
        else $error("status read");
    fault_read_a: assert property (r_q.rd && r_q.addr == 8'h08 && !x_q |->
        o_rdata[7:2] == {c_q[5:2], 1'b0, c_q[1]} && !o_rdata[0])
        else $error("fault read");
    fault_hold_a: assert property (r_q.rd && r_q.addr == 8'h08 && x_q |->
        o_rdata[7:4] == 4'h0)
        else $error("fault bits not held");
    reserved_zero_a: assert property (r_q.rd && r_q.addr == 8'h06 |->
        (o_rdata & 8'hC4) == 8'h00)
        else $error("reserved bits set");
    kick_clear_a: assert property (r_q.rd && r_q.addr == 8'h05 |->
        !o_rdata[6])
        else $error("kick bit reads one");
    ctrl_one_a: assert property (r_q.wr && r_q.addr == 8'h05 &&
        !o_host_timeout_expired |-> o_term_enable == r_q.wdata[7] &&
        o_safety_timer_enable == r_q.wdata[3])
        else $error("control one outputs");
    ctrl_two_a: assert property (r_q.wr && r_q.addr == 8'h06 &&
        !o_host_timeout_expired |-> {o_thermal_threshold_select,
        o_charger_enable, o_low_battery_threshold} ==
        {r_q.wdata[5:3], r_q.wdata[1:0]})
        else $error("control two outputs");
    expiry_a: assert property ($rose(o_host_timeout_expired) |->
        !o_charger_enable && $stable(o_low_battery_threshold))
        else $error("expiry effects");
endmodule

// *** dv/ccr_host.sv ***
`timescale 1ns/1ps
module ccr_host (
    input wire logic i_clk_sys,
    input wire logic i_rvalid,
    input wire logic [7:0] i_rdata,
    output ccr_pkg::ccr_req_s o_req
);
    initial o_req = '0;
    // Released address and data show the inverse, never the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_req <= '{1'b1, 1'b0, a, d};
        @(posedge i_clk_sys);
        o_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge i_clk_sys);
        o_req <= '{1'b0, 1'b1, a, ~a};
        @(posedge i_clk_sys);
        o_req <= '{1'b0, 1'b0, ~a, a};
        for (int i = 0; i < 3 && !ok; i++) begin
            @(posedge i_clk_sys);
            ok = i_rvalid === 1'b1;
            d = i_rdata;
        end
    endtask
endmodule

// *** dv/charger_control_status_regs_tb_top.sv ***
`timescale 1ns/1ps
module charger_control_status_regs_tb_top;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    ccr_pkg::ccr_req_s i_req;
    ccr_pkg::ccr_cond_s i_cond = '0;
    logic i_weak_detect_done = 1'b0;
    logic i_weak_detect_fail = 1'b0;
    wire [7:0] o_rdata;
    wire o_rvalid, o_term_enable, o_charger_enable, o_safety_timer_enable;
    wire o_safety_expired, o_host_timeout_expired;
    wire [1:0] o_thermal_threshold_select, o_low_battery_threshold;
    int mismatches = 0;
    int tests_run = 0;
    logic [31:0] w;
    ccr_regs #(.WD_BASE_CYCLES(20), .HOUR_CYCLES(10)) DUT (.*);
    ccr_host host (.i_clk_sys, .i_rvalid(o_rvalid), .i_rdata(o_rdata),
                   .o_req(i_req));
    always #10 i_clk_sys = ~i_clk_sys;
    task automatic close_out;
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        host.rd(a, d, ok);
        if (!ok) begin
            mismatches++;
            $display("mismatch %0t read timed out", $time);
            close_out();
        end else begin
            chk(d, exp);
        end
    endtask
    // Cycles until the selected expiry flag rises, within three of exp
    task automatic measure(input int exp, input bit wd);
        int n = 0;
        while ((wd ? o_host_timeout_expired : o_safety_expired) !== 1'b1) begin
            @(posedge i_clk_sys);
            n++;
            if (n > 600) begin
                mismatches++;
                $display("mismatch %0t expiry timed out", $time);
                close_out();
            end
        end
        tests_run++;
        if (n < exp - 3 || n > exp + 3) begin
            mismatches++;
            $display("mismatch %0t count %0d exp %0d", $time, n, exp);
        end
    endtask
    // Safety timer length in cycles for the bench's hour of 10 cycles
    function automatic int tmr_cycles(int code, bit slow);
        longint h;
        case (code)
            0: h = ccr_pkg::DUR0_H;
            1: h = ccr_pkg::DUR1_H;
            2: h = ccr_pkg::DUR2_H;
            default: h = ccr_pkg::DUR3_H;
        endcase
        return int'(h * 10 * (slow ? 2 : 1));
    endfunction
    function automatic logic [7:0] stat(ccr_pkg::ccr_cond_s c, bit f);
        if (f) return {c[5:2], 1'b0, c.cap_precharge_fail, 2'b00};
        return {c[12:9], 1'b0, c.charge_state};
    endfunction
    initial begin
        w = $urandom(24539);
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rdc(8'h05, 8'h9D);
        rdc(8'h06, 8'h33);
        rdc(8'h1C, 8'h00);
        $display("end reset values");
        for (int k = 0; k < 16; k++) begin
            w = $urandom();
            host.wr(8'h05, w[7:0] & 8'hCF);
            rdc(8'h05, w[7:0] & 8'h8F);
            host.wr(8'h06, w[15:8]);
            rdc(8'h06, w[15:8] & 8'h3B);
            @(posedge i_clk_sys) i_cond <= w[28:16];
            host.wr(8'h07, w[7:0]);
            rdc(8'h07, stat(i_cond, 1'b0));
            rdc(8'h08, stat(i_cond, 1'b1));
        end
        $display("end random access");
        @(posedge i_clk_sys) i_cond <= '0;
        for (int i = 1; i < 9; i++) begin
            @(posedge i_clk_sys);
            i_weak_detect_done <= 1'b1;
            i_weak_detect_fail <= i < 8;
            @(posedge i_clk_sys);
            i_weak_detect_done <= 1'b0;
            rdc(8'h08, (i == 7) ? 8'h02 : 8'h00);
        end
        $display("end weak adapter");
        @(posedge i_clk_sys) i_cond <= '1;
        for (int p = 1; p < 4; p++) begin
            host.wr(8'h05, {2'b11, 2'(p), 4'h0});
            host.wr(8'h06, {4'h1, 2'b10, 2'(p - 1)});
            #1 chk({7'h0, o_charger_enable}, 8'h01);
            repeat (10 * (1 << (p - 1)) - 4) @(posedge i_clk_sys);
            host.wr(8'h05, {2'b10, 2'(p), 4'h0});
            measure(10 * (1 << (p - 1)), 1'b1);
            rdc(8'h05, 8'h9D);
            rdc(8'h06, {6'h0C, 2'(p - 1)});
            rdc(8'h07, 8'hFF);
            rdc(8'h08, 8'h04);
        end
        $display("end watchdog");
        host.wr(8'h05, 8'h40);
        host.wr(8'h06, 8'h08);
        for (int t = 0; t < 4; t++) begin
            @(posedge i_clk_sys);
            i_cond <= '{charge_state: 3'h3, thermal_reg: t == 3, default: 0};
            host.wr(8'h05, 8'h01);
            host.wr(8'h05, {4'h0, 1'b1, 2'(t + 1), 1'b1});
            repeat (30) @(posedge i_clk_sys);
            host.wr(8'h05, {4'h0, 1'b1, 2'(t), 1'b1});
            measure(tmr_cycles(t, t == 3), 1'b0);
        end
        $display("end safety timer");
        close_out();
    end
endmodule
bind ccr_regs ccr_regs_properties u_props (.*);
